// ### hw/spc_chain.sv
// Pixel reduction, offset, gain and gamma correction chain
`timescale 1ns/1ps
module spc_chain #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration levels
  input wire logic [2:0] horizontal_resolution_divider,
  input wire logic test_en,
  input wire logic [spc_pkg::WORD_W-1:0] test_value,
  // Sample stream in
  input wire logic adc_valid,
  input wire logic [spc_pkg::WORD_W-1:0] adc_data,
  input wire logic [1:0] adc_color,
  input wire logic adc_last,
  output logic adc_ready_q,
  // Coefficient and table fetch
  output logic mem_req_q,
  output logic [spc_pkg::ADDR_W-1:0] mem_addr_q,
  input wire logic mem_gnt,
  input wire logic mem_rsp_valid,
  input wire logic [spc_pkg::WORD_W-1:0] mem_rsp_data,
  // Host table address mapping
  input wire logic [1:0] dp_color,
  input wire logic [spc_pkg::GIDX_W-1:0] dp_index,
  output logic [spc_pkg::ADDR_W-1:0] dp_addr_q,
  // Pixel stream out
  output logic pix_valid_q,
  output logic [spc_pkg::OUT_W-1:0] pix_data_q,
  output logic [1:0] pix_color_q,
  input wire logic pix_ready
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [1:0] col_norm(input logic [1:0] c);
    col_norm = (c == spc_pkg::COL_RED || c == spc_pkg::COL_GREEN) ? c : spc_pkg::COL_BLUE;
  endfunction : col_norm

  function automatic logic [spc_pkg::ADDR_W-1:0] gamma_addr(input logic [1:0] c,
                                                          input logic [spc_pkg::GIDX_W-1:0] i);
    gamma_addr = spc_pkg::GAMMA_BASE + (spc_pkg::ADDR_W'(col_norm(c)) << spc_pkg::COL_SHIFT_GAMMA)
                 + spc_pkg::ADDR_W'(i);
  endfunction : gamma_addr

  function automatic logic [spc_pkg::ADDR_W-1:0] coef_addr(input logic [spc_pkg::ADDR_W-1:0] base,
                                                         input logic [1:0] c,
                                                         input logic [spc_pkg::IDX_W-1:0] i);
    coef_addr = base + (spc_pkg::ADDR_W'(col_norm(c)) << spc_pkg::COL_SHIFT_COEF) + spc_pkg::ADDR_W'(i);
  endfunction : coef_addr

  function automatic logic [3:0] group_len(input logic [2:0] d);
    case (d)
      spc_pkg::DIV_1: group_len = 4'h1;
      spc_pkg::DIV_1P5: group_len = 4'h3;
      spc_pkg::DIV_2: group_len = 4'h2;
      spc_pkg::DIV_3: group_len = 4'h3;
      spc_pkg::DIV_4: group_len = 4'h4;
      spc_pkg::DIV_6: group_len = 4'h6;
      spc_pkg::DIV_8: group_len = 4'h8;
      default: group_len = 4'hc;
    endcase
  endfunction : group_len

  // Integer division truncates toward zero
  function automatic logic [spc_pkg::PIX_W-1:0] avg_div(input logic [spc_pkg::SUM_W-1:0] s,
                                                      input logic [2:0] d);
    logic [spc_pkg::SUM_W-1:0] q;
    q = '0;
    case (d)
      spc_pkg::DIV_1: q = s;
      spc_pkg::DIV_1P5: q = s / 18'h3;
      spc_pkg::DIV_2: q = s >> 1;
      spc_pkg::DIV_3: q = s / 18'h3;
      spc_pkg::DIV_4: q = s >> 2;
      spc_pkg::DIV_6: q = s / 18'h6;
      spc_pkg::DIV_8: q = s >> 3;
      default: q = s / 18'hc;
    endcase
    avg_div = q[spc_pkg::PIX_W-1:0];
  endfunction : avg_div

  // ****************************************
  // Resolution reduction
  // ****************************************
  logic [spc_pkg::PIX_W-1:0] in_pix;
  logic accept;
  logic emit;
  logic [spc_pkg::PIX_W-1:0] avg;
  logic [spc_pkg::SUM_W-1:0] sum_new;
  logic [3:0] grp_cnt_q;
  logic [spc_pkg::SUM_W-1:0] sum_q;
  logic [spc_pkg::PIX_W-1:0] prev_q;
  logic [spc_pkg::IDX_W-1:0] idx_q;
  logic grp_pend_q;
  logic grp_pend_d;
  spc_pkg::spc_sample_t grp_q;
  logic take;

  // Test value replaces the converter word but keeps the sample timing
  assign in_pix = test_en ? test_value[spc_pkg::WORD_W-1:spc_pkg::LSB_PAD]
                          : adc_data[spc_pkg::WORD_W-1:spc_pkg::LSB_PAD];
  assign accept = adc_valid && adc_ready_q;

  always_comb begin
    sum_new = sum_q + spc_pkg::SUM_W'(in_pix);
    emit = 1'b0;
    avg = '0;
    if (horizontal_resolution_divider == spc_pkg::DIV_1P5) begin
      // Three inputs make two outputs, each weighted two to one
      if (grp_cnt_q == 4'h1) begin
        emit = 1'b1;
        avg = avg_div((spc_pkg::SUM_W'(prev_q) << 1) + spc_pkg::SUM_W'(in_pix), spc_pkg::DIV_1P5);
      end else if (grp_cnt_q == 4'h2) begin
        emit = 1'b1;
        avg = avg_div(spc_pkg::SUM_W'(prev_q) + (spc_pkg::SUM_W'(in_pix) << 1), spc_pkg::DIV_1P5);
      end
    end else if (grp_cnt_q + 4'h1 == group_len(horizontal_resolution_divider)) begin
      emit = 1'b1;
      avg = avg_div(sum_new, horizontal_resolution_divider);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      grp_cnt_q <= '0;
      sum_q <= '0;
      prev_q <= '0;
    end else if (accept) begin
      prev_q <= in_pix;
      // A partial group at line end is dropped with its sum
      if (adc_last || grp_cnt_q + 4'h1 == group_len(horizontal_resolution_divider)) begin
        grp_cnt_q <= '0;
        sum_q <= '0;
      end else begin
        grp_cnt_q <= grp_cnt_q + 4'h1;
        sum_q <= sum_new;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idx_q <= '0;
    end else if (accept) begin
      if (adc_last) begin
        idx_q <= '0;
      end else if (emit) begin
        idx_q <= idx_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Hand-off to correction
  // ****************************************
  always_comb begin
    grp_pend_d = grp_pend_q;
    if (take) begin
      grp_pend_d = 1'b0;
    end
    if (accept && emit) begin
      grp_pend_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      grp_pend_q <= 1'b0;
      adc_ready_q <= 1'b0;
      grp_q <= '0;
    end else begin
      grp_pend_q <= grp_pend_d;
      // Ready is held low while a reduced pixel waits, costing at least one idle cycle per reduced pixel, more while the sequencer is busy
      adc_ready_q <= !grp_pend_d;
      if (accept && emit) begin
        grp_q <= '{color: adc_color, idx: idx_q, value: avg};
      end
    end
  end

  // ****************************************
  // Correction sequencer
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_OFS, ST_GAIN, ST_GAM, ST_PUSH} spc_state_t;

  spc_state_t state_q;
  spc_pkg::spc_sample_t cur_q;
  logic [spc_pkg::PIX_W-1:0] ofs_q;
  logic [spc_pkg::PIX_W-1:0] gain_q;
  logic [spc_pkg::OUT_W-1:0] gam_q;
  logic [spc_pkg::PIX_W-1:0] ofs_val;
  logic [spc_pkg::PIX_W-1:0] coef_top;
  logic [spc_pkg::PIX_W+spc_pkg::WORD_W-1:0] prod;
  logic [spc_pkg::PIX_W+spc_pkg::WORD_W-1:0] scaled;
  logic [spc_pkg::PIX_W-1:0] gain_val;
  logic rsp_ok;
  logic fifo_in_ready;
  spc_pkg::spc_pixel_t fifo_out;
  logic fifo_out_valid;

  assign take = (state_q == ST_IDLE) && grp_pend_q;
  assign rsp_ok = mem_rsp_valid && !mem_req_q;

  always_comb begin
    coef_top = mem_rsp_data[spc_pkg::WORD_W-1:spc_pkg::LSB_PAD];
    ofs_val = (coef_top > cur_q.value) ? '0 : cur_q.value - coef_top;
    prod = (spc_pkg::PIX_W+spc_pkg::WORD_W)'(ofs_q) * (spc_pkg::PIX_W+spc_pkg::WORD_W)'(mem_rsp_data);
    scaled = prod >> spc_pkg::GAIN_SHIFT;
    gain_val = (scaled > (spc_pkg::PIX_W+spc_pkg::WORD_W)'(spc_pkg::PIX_MAX)) ? spc_pkg::PIX_MAX
               : scaled[spc_pkg::PIX_W-1:0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (take) begin
          state_q <= ST_OFS;
        end
        ST_OFS: if (rsp_ok) begin
          state_q <= ST_GAIN;
        end
        ST_GAIN: if (rsp_ok) begin
          state_q <= ST_GAM;
        end
        ST_GAM: if (rsp_ok) begin
          state_q <= ST_PUSH;
        end
        ST_PUSH: if (fifo_in_ready) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_q <= '0;
      ofs_q <= '0;
      gain_q <= '0;
      gam_q <= '0;
    end else begin
      if (take) begin
        cur_q <= grp_q;
      end
      if (state_q == ST_OFS && rsp_ok) begin
        ofs_q <= ofs_val;
      end
      if (state_q == ST_GAIN && rsp_ok) begin
        gain_q <= gain_val;
      end
      if (state_q == ST_GAM && rsp_ok) begin
        gam_q <= mem_rsp_data[spc_pkg::OUT_W-1:0];
      end
    end
  end

  // Request is held until granted; the answer is only taken after the grant
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= '0;
    end else if (mem_req_q) begin
      if (mem_gnt) begin
        mem_req_q <= 1'b0;
      end
    end else if (take) begin
      mem_req_q <= 1'b1;
      mem_addr_q <= coef_addr(spc_pkg::OFS_BASE, grp_q.color, grp_q.idx);
    end else if (state_q == ST_OFS && rsp_ok) begin
      mem_req_q <= 1'b1;
      mem_addr_q <= coef_addr(spc_pkg::GAIN_BASE, cur_q.color, cur_q.idx);
    end else if (state_q == ST_GAIN && rsp_ok) begin
      mem_req_q <= 1'b1;
      mem_addr_q <= gamma_addr(cur_q.color, gain_val[spc_pkg::PIX_W-1:spc_pkg::LSB_PAD]);
    end
  end

  // ****************************************
  // Host table address mapping
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      dp_addr_q <= '0;
    end else begin
      dp_addr_q <= gamma_addr(dp_color, dp_index);
    end
  end

  // ****************************************
  // Output buffer
  // ****************************************
  spc_fifo #(
    .WIDTH(spc_pkg::PIXEL_T_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(state_q == ST_PUSH),
    .in_data({cur_q.color, gam_q}),
    .in_ready(fifo_in_ready),
    .out_valid_q(fifo_out_valid),
    .out_data_q(fifo_out),
    .out_ready(pix_ready)
  );

  assign pix_valid_q = fifo_out_valid;
  assign pix_data_q = fifo_out.value;
  assign pix_color_q = fifo_out.color;

endmodule : spc_chain

// ### inc/spc_pkg.sv
// Package of constants and types for the scanner pixel correction chain
// Overview of operation
// - Input samples are 16-bit words, pixel in bits 15..2, low two bits zero.
// - Horizontal reduction factors 1, 1.5, 2, 3, 4, 6, 8 and 12 are selectable.
// - Reduction averages adjacent pixels in a group; drops an incomplete trailing group, at factor 1.5 only a single trailing pixel.
// - Output pixels per line equal integer part of input count over factor.
// - Trailing pixels that cannot complete a group are discarded at line end, except that at factor 1.5 two trailing pixels still give one output.
// - Reduced pixels go through offset, then gain, then gamma, in that order.
// - Each pixel fetches its own 16-bit offset coefficient and subtracts it.
// - Offset subtraction clamps at zero instead of wrapping negative.
// - Offset difference uses only the top 14 bits of both words.
// - Gain multiplies by the pixel's 16-bit coefficient and divides by 16384.
// - Gain output clamps at 16383 when the scaled product exceeds it.
// - Coefficient zero gives zero gain; 16384 gives unity gain.
// - Red, green and blue tables indexed by top 12 bits, return 8 bits.
// - Tables take 12k words of memory; only low 8 bits are used.
// - Table contents are arbitrary; no fixed curve is imposed.
// - Coefficient port selects which colour table an access targets.
// - Test mode replaces the reduction input with a fixed host value.
package spc_pkg;

  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int unsigned PIX_W = 14;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned OUT_W = 8;
  localparam int unsigned GIDX_W = 12;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned IDX_W = 14;
  localparam int unsigned SUM_W = 18;
  localparam int unsigned LSB_PAD = 2;

  localparam logic [2:0] DIV_1 = 3'h0;
  localparam logic [2:0] DIV_1P5 = 3'h1;
  localparam logic [2:0] DIV_2 = 3'h2;
  localparam logic [2:0] DIV_3 = 3'h3;
  localparam logic [2:0] DIV_4 = 3'h4;
  localparam logic [2:0] DIV_6 = 3'h5;
  localparam logic [2:0] DIV_8 = 3'h6;
  localparam logic [2:0] DIV_12 = 3'h7;

  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_BLUE = 2'h2;

  // ****************************************
  // Arithmetic constants
  // ****************************************
  localparam logic [PIX_W-1:0] PIX_MAX = 14'h3fff;
  localparam int unsigned GAIN_SHIFT = 14;

  // ****************************************
  // External memory map in words
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_BASE = 20'h00000;
  localparam logic [ADDR_W-1:0] GAIN_BASE = 20'h0c000;
  localparam logic [ADDR_W-1:0] GAMMA_BASE = 20'h18000;
  localparam int unsigned COL_SHIFT_COEF = 14;
  localparam int unsigned COL_SHIFT_GAMMA = 12;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] color;
    logic [IDX_W-1:0] idx;
    logic [PIX_W-1:0] value;
  } spc_sample_t;

  typedef struct packed {
    logic [1:0] color;
    logic [OUT_W-1:0] value;
  } spc_pixel_t;

  localparam int unsigned PIXEL_T_W = $bits(spc_pixel_t);

endpackage : spc_pkg

// ### hw/spc_fifo.sv
// Synchronous FIFO with registered output stage
`timescale 1ns/1ps
module spc_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid_q,
  output logic [WIDTH-1:0] out_data_q,
  input wire logic out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (cnt_q != '0) && (!out_valid_q || out_ready);

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ****************************************
  // Output register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule : spc_fifo

// ### sim/spc_chain_chk.sv
// Port checks for the pixel correction chain
`timescale 1ns/1ps
module spc_chain_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Samples
  input wire logic [2:0] horizontal_resolution_divider,
  input wire logic adc_valid,
  input wire logic adc_ready_q,
  // Fetches
  input wire logic mem_req_q,
  input wire logic [19:0] mem_addr_q,
  input wire logic mem_gnt,
  input wire logic mem_rsp_valid,
  // Table mapping
  input wire logic [1:0] dp_color,
  input wire logic [11:0] dp_index,
  input wire logic [19:0] dp_addr_q,
  // Pixels
  input wire logic pix_valid_q,
  input wire logic [7:0] pix_data_q,
  input wire logic [1:0] pix_color_q,
  input wire logic pix_ready
);
  // ***
  // Fetch tracking
  // ***
  logic [1:0] rg;
  logic [1:0] last_q;
  logic [19:0] ofs_q;
  logic pend_q;
  assign rg = (mem_addr_q >= spc_pkg::GAMMA_BASE) ? 2'h2 : (mem_addr_q >= spc_pkg::GAIN_BASE) ? 2'h1 : 2'h0;
  always_ff @(posedge clk) begin
    if (srst) begin
      last_q <= 2'h2;
      ofs_q <= 20'h0;
    end else if (mem_req_q && mem_gnt) begin
      last_q <= rg;
      if (rg == 2'h0) begin
        ofs_q <= mem_addr_q;
      end
    end
  end
  // Open between grant and answer; a new request here would race the data
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (mem_req_q && mem_gnt) begin
      pend_q <= 1'b1;
    end else if (mem_rsp_valid) begin
      pend_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_req_hold;
    mem_req_q && !mem_gnt |=> mem_req_q && $stable(mem_addr_q);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  property p_gnt_drop;
    mem_req_q && mem_gnt |=> !mem_req_q;
  endproperty
  a_gnt_drop: assert property (p_gnt_drop) else $error("request kept");
  property p_stall;
    pend_q |-> !mem_req_q;
  endproperty
  a_stall: assert property (p_stall) else $error("request before answer");
  property p_order;
    mem_req_q |-> rg == ((last_q == 2'h2) ? 2'h0 : last_q + 2'h1);
  endproperty
  a_order: assert property (p_order) else $error("fetch order");
  property p_own_gain;
    mem_req_q && rg == 2'h1 |-> mem_addr_q == ofs_q + spc_pkg::GAIN_BASE;
  endproperty
  a_own_gain: assert property (p_own_gain) else $error("gain address");
  property p_gamma_span;
    mem_req_q && rg == 2'h2 |-> mem_addr_q < spc_pkg::GAMMA_BASE + 20'h03000;
  endproperty
  a_gamma_span: assert property (p_gamma_span) else $error("table address");
  property p_dp_map;
    !$past(srst) |-> dp_addr_q == spc_pkg::GAMMA_BASE
      + {($past(dp_color) == 2'h3) ? 2'h2 : $past(dp_color), $past(dp_index)};
  endproperty
  a_dp_map: assert property (p_dp_map) else $error("port address");
  property p_div1;
    adc_valid && adc_ready_q && horizontal_resolution_divider == spc_pkg::DIV_1 |=> !adc_ready_q;
  endproperty
  a_div1: assert property (p_div1) else $error("sample not grouped");
  property p_pix_hold;
    pix_valid_q && !pix_ready |=> pix_valid_q && $stable({pix_data_q, pix_color_q});
  endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("pixel dropped");
endmodule : spc_chain_chk

// ### sim/spc_mem_model.sv
// Coefficient and table memory on the fetch port
`timescale 1ns/1ps
module spc_mem_model (
  // Clock and pace
  input wire logic clk,
  input wire logic slow,
  // Fetch port
  input wire logic mem_req_q,
  input wire logic [19:0] mem_addr_q,
  output logic mem_gnt,
  output logic mem_rsp_valid,
  output logic [15:0] mem_rsp_data
);
  // ***
  // Contents and answers
  // ***
  logic [19:0] a;
  function automatic logic [15:0] word(input logic [19:0] x);
    if (x >= spc_pkg::GAMMA_BASE) return {~x[7:0], x[11:4] ^ {6'h0, x[13:12]}};
    if (x >= spc_pkg::GAIN_BASE) begin
      case (x[1:0])
        2'h0: return 16'h4000;
        2'h1: return 16'h0000;
        2'h2: return 16'hffff;
        default: return {2'h0, x[5:2], 10'h155};
      endcase
    end
    return (x[2:0] == 3'h5) ? 16'hfffc : {4'h0, x[7:0], 4'h0};
  endfunction : word
  // Slow pace stretches grant and answer so stalls are exercised
  initial begin
    mem_gnt = 1'b0;
    mem_rsp_valid = 1'b0;
    mem_rsp_data = 16'h0;
    @(posedge clk);
    #1;
    forever begin
      if (mem_req_q !== 1'b1) begin
        @(posedge clk);
        #1;
      end else begin
        a = mem_addr_q;
        repeat (slow ? a[1:0] : 2'h0) begin
          @(posedge clk);
          #1;
        end
        mem_gnt = 1'b1;
        @(posedge clk);
        #1;
        mem_gnt = 1'b0;
        repeat (slow ? a[3:2] : 2'h0) begin
          @(posedge clk);
          #1;
        end
        mem_rsp_valid = 1'b1;
        mem_rsp_data = word(a);
        @(posedge clk);
        #1;
        mem_rsp_valid = 1'b0;
        mem_rsp_data = ~mem_rsp_data;
      end
    end
  end
endmodule : spc_mem_model

// ### sim/test_spc_chain.sv
// Self-checking bench for the pixel correction chain
`timescale 1ns/1ps
module test_spc_chain;
  // ***
  // Stimulus and checks
  // ***
  logic clk, srst, test_en, adc_valid, adc_last, adc_ready_q, mem_req_q, mem_gnt, mem_rsp_valid;
  logic pix_valid_q, pix_ready, slow;
  logic [2:0] horizontal_resolution_divider;
  logic [15:0] test_value, adc_data, mem_rsp_data;
  logic [1:0] adc_color, dp_color, pix_color_q;
  logic [11:0] dp_index;
  logic [19:0] mem_addr_q, dp_addr_q;
  logic [7:0] pix_data_q;
  logic [31:0] seed;
  int n_errors, compares, rdy_mode, k;
  int nf[8] = '{1, 3, 2, 3, 4, 6, 8, 12};
  spc_pkg::spc_pixel_t q[$];
  spc_chain #(.FIFO_DEPTH(16)) u_spc_chain (.clk, .srst, .horizontal_resolution_divider, .test_en,
    .test_value, .adc_valid, .adc_data, .adc_color, .adc_last, .adc_ready_q, .mem_req_q, .mem_addr_q,
    .mem_gnt, .mem_rsp_valid, .mem_rsp_data, .dp_color, .dp_index, .dp_addr_q, .pix_valid_q,
    .pix_data_q, .pix_color_q, .pix_ready);
  spc_mem_model u_spc_mem_model (.clk, .slow, .mem_req_q, .mem_addr_q, .mem_gnt, .mem_rsp_valid, .mem_rsp_data);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Expected byte for a reduced pixel, from the memory contents
  task automatic note(input logic [13:0] p, input logic [1:0] c, inout int i);
    logic [15:0] w;
    logic [13:0] d;
    logic [31:0] g;
    logic [1:0] cn;
    spc_pkg::spc_pixel_t r;
    // Colour code 3 fetches from the blue tables but keeps its own tag on the output
    cn = (c == 2'h3) ? spc_pkg::COL_BLUE : c;
    w = u_spc_mem_model.word(spc_pkg::OFS_BASE + {cn, 14'(i)});
    d = (p > w[15:2]) ? p - w[15:2] : 14'h0;
    g = (32'(d) * u_spc_mem_model.word(spc_pkg::GAIN_BASE + {cn, 14'(i)})) >> 14;
    if (g > 32'h3fff) g = 32'h3fff;
    w = u_spc_mem_model.word(spc_pkg::GAMMA_BASE + {cn, g[13:2]});
    r.color = c;
    r.value = w[7:0];
    q.push_back(r);
    i++;
  endtask : note
  task automatic put(input logic [13:0] p, input logic [1:0] c, input logic l);
    int t;
    adc_valid = 1'b1;
    adc_data = {p, 2'h0};
    adc_color = c;
    adc_last = l;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (adc_ready_q !== 1'b1 && t < 3000);
    #1;
    check("sample_taken", 20'h1, 20'(t < 3000));
  endtask : put
  task automatic line(input logic [2:0] dv, input int n);
    int j, s, i;
    logic [13:0] p, v, pv;
    logic [1:0] c;
    horizontal_resolution_divider = dv;
    j = 0;
    s = 0;
    i = 0;
    for (int m = 0; m < n; m++) begin
      p = 14'(rnd());
      c = 2'(rnd());
      put(p, c, m == n - 1);
      v = test_en ? test_value[15:2] : p;
      s += v;
      if (dv == spc_pkg::DIV_1P5 && j == 1) note(14'((2 * pv + v) / 3), c, i);
      else if (dv == spc_pkg::DIV_1P5 && j == 2) note(14'((pv + 2 * v) / 3), c, i);
      else if (dv != spc_pkg::DIV_1P5 && j == nf[dv] - 1) note(14'(s / nf[dv]), c, i);
      pv = v;
      j++;
      if (j == nf[dv]) begin
        j = 0;
        s = 0;
      end
    end
    adc_valid = 1'b0;
  endtask : line
  task automatic drain(input string name);
    for (int t = 0; t < 5000 && q.size() != 0; t++) @(posedge clk);
    // Settle time so that a stray extra pixel still shows up here
    repeat (40) @(posedge clk);
    #1;
    check("pixels_left", 20'h0, 20'(q.size()));
    $display("Test %s done", name);
  endtask : drain
  always @(posedge clk) begin
    if (srst === 1'b0 && pix_valid_q === 1'b1 && pix_ready === 1'b1) begin
      if (q.size() == 0) check("extra_pixel", 20'h0, 20'h1);
      else check("pixel", 20'(q.pop_front()), {10'h0, pix_color_q, pix_data_q});
    end
  end
  always @(posedge clk) begin
    #1;
    pix_ready = (rdy_mode == 1) && (rnd() % 4 != 0);
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    seed = 32'd20308;
    {srst, test_en, adc_valid, adc_last, slow, pix_ready} = 6'h20;
    {horizontal_resolution_divider, test_value, adc_data, adc_color, dp_color, dp_index} = '0;
    rdy_mode = 1;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    #1;
    for (k = 0; k < 4; k++) begin
      dp_color = 2'(k);
      dp_index = 12'(rnd());
      @(posedge clk);
      #1;
      check("dp_addr", spc_pkg::GAMMA_BASE + {(dp_color == 2'h3) ? spc_pkg::COL_BLUE : dp_color, dp_index},
            dp_addr_q);
    end
    $display("Test table_port done");
    for (k = 0; k < 8; k++) begin
      slow = k[0];
      line(3'(k), 35);
      drain("divider");
    end
    test_en = 1'b1;
    test_value = {14'(rnd()), 2'h0};
    line(spc_pkg::DIV_2, 9);
    drain("test_mode");
    test_en = 1'b0;
    rdy_mode = 0;
    fork
      line(spc_pkg::DIV_1, 30);
      begin
        repeat (1000) @(posedge clk);
        #1;
        check("stalled", 20'h1, {18'h0, adc_ready_q, pix_valid_q});
        rdy_mode = 1;
      end
    join
    drain("back_pressure");
    complete_run();
  end
endmodule : test_spc_chain
bind spc_chain spc_chain_chk u_spc_chain_chk (.clk, .srst, .horizontal_resolution_divider, .adc_valid,
  .adc_ready_q, .mem_req_q, .mem_addr_q, .mem_gnt, .mem_rsp_valid, .dp_color, .dp_index, .dp_addr_q,
  .pix_valid_q, .pix_data_q, .pix_color_q, .pix_ready);
